// >>> verilog/cfd_params.svh
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH
// ----------------------------------------
// register addresses (7-bit)
// ----------------------------------------
`define CFD_ADDR_GLOBAL  7'h50
`define CFD_ADDR_FAULT   7'h54
`define CFD_FAULT_RESET  7'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define CFD_GS_GLOBAL    7
`define CFD_GS_SERIAL_FRAME_ERROR_FLAG    6
`define CFD_GS_BUSFAULT  0
`define CFD_CMD_WRITE    1'b1
// ----------------------------------------
// frame lengths in serial clocks
// ----------------------------------------
`define CFD_LEN_ONE      6'h10
`define CFD_LEN_TWO      6'h18
`define CFD_LEN_THREE    6'h20
`define CFD_LEN_CMD      6'h08
`define CFD_CNT_MAX      6'h3F
// ----------------------------------------
// timing
// ----------------------------------------
`define CFD_CLK_NS       10
`define CFD_DOM_MIN_NS   2000
`define CFD_PERSIST      3'h4
`endif

// >>> verilog/cfd_pkg.sv
package cfd_pkg;
    // fault detector inputs, msb is bit 6 of the flag register
    typedef struct packed {
        logic half_termination_flag;
        logic lines_shorted_together_flag;
        logic high_line_to_battery_flag;
        logic low_line_to_ground_flag;
        logic bus_open_flag;
        logic short_to_ground_flag;
        logic short_to_battery_flag;
    } cfd_fault_type;
    // operating mode
    typedef enum logic [1:0] {
        CFD_MODE_NORMAL    = 2'b00,
        CFD_MODE_SLEEP     = 2'b01,
        CFD_MODE_FAIL_SAFE = 2'b10
    } cfd_mode_type;
    // serial clock domain record of the frame
    typedef struct packed {
        logic [5:0]      bit_cnt;
        logic [7:0]      shift;
        logic [6:0]      addr;
        logic            rw;
        logic [2:0][7:0] data;
        logic            frame_tag;
    } cfd_link_type;
    // core clock domain state
    typedef struct packed {
        logic [2:0][9:0] sy;
        logic [9:0]      lvl;
        logic [11:0]     dom_time;
        logic [6:0][2:0] persist;
        cfd_fault_type   flags;
        logic            spi_err;
        logic            seen_tag;
        logic [7:0]      snap_status;
        logic [6:0]      snap_flags;
        cfd_mode_type    mode;
    } cfd_core_type;
endpackage : cfd_pkg

// >>> verilog/cfd_spi_fault.sv
`timescale 1ns/100ps
`include "cfd_params.svh"
// Function
// - frames are 16, 24 or 32 clocks
// - burst bytes use incremented addresses
// - global status byte shifted out first
// - sample serial in on rising edge
// - change serial out on falling edge
// - serial out released while deselected
// - driver on whenever chip select low
// - global fault bit shown at select
// - fault needs four qualified dominant releases
// - bits 6,5,4 half-term, lines, high-battery
// - bits 3,2 low-ground, bus open
// - bits 1,0 ground, battery; bit7 zero
// - fail-safe enable during sleep stays sleep
// - command is 7-bit address plus r/w
// - writes commit at deselect, whole bytes
// - bad clock count sets frame error
// - first bit is global register bit 7
module cfd_spi_fault (
    input  wire logic                  clock_in,
    input  wire logic                  reset_in,
    input  wire logic                  spi_clock_in,
    input  wire logic                  chip_select_n_in,
    input  wire logic                  serial_in,
    output logic                       serial_out_out,
    output logic                       serial_out_oe_n_out,
    input  wire logic                  bus_dominant_in,
    input  wire cfd_pkg::cfd_fault_type fault_detect_in,
    input  wire logic                  sleep_fault_in,
    input  wire logic                  fail_safe_enable_in,
    input  wire logic                  wake_request_in,
    output logic [7:0]                 bus_fault_status_flags_out,
    output logic                       serial_frame_error_flag_out,
    output logic                       sleep_mode_out,
    output logic                       fail_safe_mode_out
);
    import cfd_pkg::*;

    // ----------------------------------------
    // constants
    // ----------------------------------------
    // least dominant time, rounded up to cycles
    localparam int DOM_CYC =
        (`CFD_DOM_MIN_NS + `CFD_CLK_NS - 1) / `CFD_CLK_NS;
    localparam logic [11:0] DOM_CYC_W = 12'(DOM_CYC);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // readable register contents by address
    function automatic logic [7:0] reg_read(
        input logic [6:0] addr,
        input logic [7:0] status,
        input logic [6:0] flags
    );
        reg_read = 8'h00;
        if (addr == `CFD_ADDR_GLOBAL) begin
            reg_read = status;
        end else if (addr == `CFD_ADDR_FAULT) begin
            reg_read = {1'b0, flags};
        end
    endfunction : reg_read

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    cfd_core_type     core_q;              // core state
    cfd_core_type     core_d;              // core next state
    cfd_link_type     lnk_q;               // frame record
    cfd_link_type     lnk_d;               // frame record next
    logic [5:0]       cnt_q;               // clocks in this frame
    logic [5:0]       cnt_d;               // clocks next
    logic [1:0]       neg_q;               // {fell, bit} on falling edge
    logic [1:0]       neg_d;               // falling edge next
    logic             lnk_rst;             // frame reset
    logic [7:0]       status_now;          // global status byte
    logic [9:0]       pins;                // asynchronous inputs
    logic [9:0]       agree;               // 2nd and 3rd flop agree
    logic [6:0]       set_vec;             // flags set this cycle
    logic [6:0]       clr_vec;             // flags cleared by write
    logic             clr_err;             // frame error clear
    logic             err_set;             // frame error event
    logic             qual;                // qualified dominant release
    logic             commit;              // chip select rose
    logic [5:0]       clocks;              // clocks of finished frame
    logic [1:0]       nbytes;              // whole data bytes
    logic [6:0]       waddr;               // burst write address
    logic [7:0]       tx_byte;             // byte being shifted out
    logic [2:0]       k_idx;               // outgoing byte index
    logic [1:0]       wr_idx;              // incoming data byte index

    // ----------------------------------------
    // core domain
    // ----------------------------------------
    assign pins = {chip_select_n_in, bus_dominant_in, sleep_fault_in,
                   fault_detect_in};
    // global fault, frame error and any bus fault
    assign status_now = {(|core_q.flags) | core_q.spi_err,
                         core_q.spi_err, 5'h00, |core_q.flags};

    // next state of the core
    always_comb begin
        core_d  = core_q;
        set_vec = 7'h00;
        clr_vec = 7'h00;
        clr_err = 1'b0;
        err_set = 1'b0;
        clocks  = 6'h00;
        nbytes  = 2'h0;
        waddr   = 7'h00;
        // three flops; change counts once 2nd and 3rd agree
        core_d.sy  = {core_q.sy[1], core_q.sy[0], pins};
        agree      = ~(core_q.sy[1] ^ core_q.sy[2]);
        core_d.lvl = (agree & core_q.sy[2]) | (~agree & core_q.lvl);
        // dominant duration, saturating
        if (core_q.lvl[8]) begin
            if (core_q.dom_time != 12'hFFF) begin
                core_d.dom_time = core_q.dom_time + 12'h001;
            end
        end else begin
            core_d.dom_time = 12'h000;
        end
        // dominant to recessive after a long enough bit
        qual = core_q.lvl[8] & ~core_d.lvl[8]
             & (core_q.dom_time >= DOM_CYC_W);
        // persistence per fault over qualified releases
        for (int i = 0; i < 7; i++) begin
            if (!core_q.lvl[i]) begin
                core_d.persist[i] = 3'h0;
            end else if (qual && core_q.persist[i] != `CFD_PERSIST) begin
                core_d.persist[i] = core_q.persist[i] + 3'h1;
            end
            // recorded on the fourth one
            set_vec[i] = (core_d.persist[i] == `CFD_PERSIST);
        end
        // finished frame, record stable once select is high
        commit = ~core_q.lvl[9] & core_d.lvl[9];
        if (commit) begin
            // unchanged tag means no clock in this frame
            if (lnk_q.frame_tag != core_q.seen_tag) begin
                clocks = lnk_q.bit_cnt;
            end
            core_d.seen_tag = lnk_q.frame_tag;
            // only exact lengths are valid
            err_set = (clocks != `CFD_LEN_ONE) && (clocks != `CFD_LEN_TWO)
                   && (clocks != `CFD_LEN_THREE);
            // whole bytes received; 31 clocks commit two
            if (clocks >= `CFD_LEN_THREE) begin
                nbytes = 2'h3;
            end else if (clocks >= `CFD_LEN_TWO) begin
                nbytes = 2'h2;
            end else if (clocks >= `CFD_LEN_ONE) begin
                nbytes = 2'h1;
            end
            // write command, one register per byte
            if (lnk_q.rw == `CFD_CMD_WRITE) begin
                for (int k = 0; k < 3; k++) begin
                    waddr = lnk_q.addr + 7'(k);
                    if (2'(k) < nbytes) begin
                        if (waddr == `CFD_ADDR_FAULT) begin
                            clr_vec = clr_vec | lnk_q.data[k][6:0];
                        end
                        if (waddr == `CFD_ADDR_GLOBAL) begin
                            clr_err = clr_err
                                    | lnk_q.data[k][`CFD_GS_SERIAL_FRAME_ERROR_FLAG];
                        end
                    end
                end
            end
        end
        // set wins over clear, read never clears
        core_d.flags   = (core_q.flags & ~clr_vec) | set_vec;
        core_d.spi_err = (core_q.spi_err & ~clr_err) | err_set;
        // snapshot held still while selected
        if (core_q.lvl[9]) begin
            core_d.snap_status = status_now;
            core_d.snap_flags  = core_d.flags;
        end
        // mode machine
        unique case (core_q.mode)
            CFD_MODE_NORMAL: begin
                // rise of the filtered sleep fault checks the enable once
                if (core_d.lvl[7] && !core_q.lvl[7]) begin
                    core_d.mode = fail_safe_enable_in ? CFD_MODE_FAIL_SAFE
                                                      : CFD_MODE_SLEEP;
                end
            end
            CFD_MODE_SLEEP: begin
                // enable now is ignored, only wake leaves
                if (wake_request_in) begin
                    core_d.mode = CFD_MODE_NORMAL;
                end
            end
            CFD_MODE_FAIL_SAFE: begin
                if (wake_request_in) begin
                    core_d.mode = CFD_MODE_NORMAL;
                end
            end
            default: begin
                core_d.mode = CFD_MODE_NORMAL;
            end
        endcase
    end

    // core register
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            core_q          <= '0;
            core_q.sy       <= {3{10'h200}};  // idle pins, no false edge
            core_q.lvl      <= 10'h200;
            core_q.flags    <= `CFD_FAULT_RESET;
            core_q.mode     <= CFD_MODE_NORMAL;
        end else begin
            core_q <= core_d;
        end
    end

    // ----------------------------------------
    // serial clock domain, rising edge
    // ----------------------------------------
    // frame ends, or chip reset, restart the count
    assign lnk_rst = reset_in | chip_select_n_in;

    // shift in and record the frame
    always_comb begin
        lnk_d  = lnk_q;
        cnt_d  = (cnt_q == `CFD_CNT_MAX) ? cnt_q : cnt_q + 6'h01;
        wr_idx = 2'h0;
        lnk_d.shift   = {lnk_q.shift[6:0], serial_in};
        lnk_d.bit_cnt = cnt_d;
        // tag marks that the frame saw a clock
        if (cnt_q == 6'h00) begin
            lnk_d.frame_tag = ~lnk_q.frame_tag;
        end
        // command byte: address then r/w
        if (cnt_d == `CFD_LEN_CMD) begin
            lnk_d.addr = lnk_d.shift[7:1];
            lnk_d.rw   = lnk_d.shift[0];
        end
        // data bytes of the burst
        if (cnt_d[2:0] == 3'h0 && cnt_d >= `CFD_LEN_ONE
            && cnt_d <= `CFD_LEN_THREE) begin
            wr_idx = cnt_d[4:3] - 2'h2;
            if (cnt_d == `CFD_LEN_THREE) begin
                wr_idx = 2'h2;
            end
            lnk_d.data[wr_idx] = lnk_d.shift;
        end
    end

    // frame record keeps its value after deselect
    always_ff @(posedge spi_clock_in or posedge reset_in) begin
        if (reset_in) begin
            lnk_q <= '0;
        end else begin
            lnk_q <= lnk_d;
        end
    end

    // clock counter of the current frame
    always_ff @(posedge spi_clock_in or posedge lnk_rst) begin
        if (lnk_rst) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // serial clock domain, falling edge
    // ----------------------------------------
    // next outgoing bit, index is clocks seen
    always_comb begin
        k_idx   = cnt_q[5:3];
        tx_byte = 8'h00;
        if (k_idx == 3'h0) begin
            tx_byte = core_q.snap_status;
        end else if (lnk_q.rw != `CFD_CMD_WRITE && k_idx <= 3'h3) begin
            tx_byte = reg_read(lnk_q.addr + 7'(k_idx - 3'h1),
                               core_q.snap_status,
                               core_q.snap_flags);
        end
        neg_d = {1'b1, tx_byte[3'h7 - cnt_q[2:0]]};
    end

    // output bit changes on falling edge only
    always_ff @(negedge spi_clock_in or posedge lnk_rst) begin
        if (lnk_rst) begin
            neg_q <= 2'b00;
        end else begin
            neg_q <= neg_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // before first falling edge show global fault bit
    assign serial_out_out = neg_q[1] ? neg_q[0]
                          : core_q.snap_status[`CFD_GS_GLOBAL];
    // active low enable follows select
    assign serial_out_oe_n_out = chip_select_n_in;
    assign bus_fault_status_flags_out = {1'b0, core_q.flags};
    assign serial_frame_error_flag_out = core_q.spi_err;
    assign sleep_mode_out = (core_q.mode == CFD_MODE_SLEEP);
    assign fail_safe_mode_out = (core_q.mode == CFD_MODE_FAIL_SAFE);
endmodule : cfd_spi_fault

// >>> bench/cfd_spi_fault_properties.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module cfd_spi_fault_properties (
    input wire logic                   clock_in,
    input wire logic                   reset_in,
    input wire logic                   spi_clock_in,
    input wire logic                   chip_select_n_in,
    input wire logic                   serial_out_out,
    input wire logic                   serial_out_oe_n_out,
    input wire cfd_pkg::cfd_fault_type fault_detect_in,
    input wire logic [7:0]             bus_fault_status_flags_out,
    input wire logic                   serial_frame_error_flag_out,
    input wire logic                   sleep_mode_out,
    input wire logic                   fail_safe_mode_out
);
    import cfd_pkg::*;
    logic [3:0] gap_q; // cycles since chip select was last low
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // saturating count after deselect
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            gap_q <= 4'hF;
        end else if (!chip_select_n_in) begin
            gap_q <= 4'h0;
        end else if (gap_q != 4'hF) begin
            gap_q <= gap_q + 4'h1;
        end
    end
    // frame effects land shortly after deselect
    sequence s_after_deselect;
        chip_select_n_in && gap_q <= 4'h7;
    endsequence
    property p_oe_follows_cs;
        serial_out_oe_n_out == chip_select_n_in;
    endproperty
    property p_out_holds_high;
        !chip_select_n_in && !$past(chip_select_n_in) && spi_clock_in && $past(spi_clock_in)
            |-> $stable(serial_out_out);
    endproperty
    property p_reserved_zero;
        !bus_fault_status_flags_out[7];
    endproperty
    property p_clear_after_deselect;
        |($past(bus_fault_status_flags_out[6:0]) & ~bus_fault_status_flags_out[6:0])
            |-> s_after_deselect;
    endproperty
    property p_error_after_deselect;
        $rose(serial_frame_error_flag_out) |-> s_after_deselect;
    endproperty
    property p_flag_needs_fault;
        ((bus_fault_status_flags_out[6:0] & ~$past(bus_fault_status_flags_out[6:0]))
            & ~$past(fault_detect_in, 4)) == 7'h00;
    endproperty
    property p_sleep_no_fail_safe;
        sleep_mode_out |=> !fail_safe_mode_out;
    endproperty
    property p_first_bit;
        $fell(chip_select_n_in) |->
            serial_out_out == ((|bus_fault_status_flags_out) | serial_frame_error_flag_out);
    endproperty
    property p_err_stable_in_frame;
        !chip_select_n_in && !$past(chip_select_n_in) |-> $stable(serial_frame_error_flag_out);
    endproperty
    a_oe_follows_cs: assert property (p_oe_follows_cs)
        else $error("output enable differs from chip select");
    a_out_holds_high: assert property (p_out_holds_high)
        else $error("serial out moved while serial clock high");
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved flag bit set");
    a_clear_after_deselect: assert property (p_clear_after_deselect)
        else $error("fault flag cleared without a frame");
    a_error_after_deselect: assert property (p_error_after_deselect)
        else $error("frame error set outside deselect");
    a_flag_needs_fault: assert property (p_flag_needs_fault)
        else $error("flag set without its fault");
    a_sleep_no_fail_safe: assert property (p_sleep_no_fail_safe)
        else $error("sleep moved into fail safe");
    a_first_bit: assert property (p_first_bit)
        else $error("first serial bit not global flag");
    a_err_stable_in_frame: assert property (p_err_stable_in_frame)
        else $error("frame error changed mid frame");
endmodule : cfd_spi_fault_properties

// >>> bench/cfd_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// spi controller model, mode 0, idle low
// ----------------------------------------
module cfd_host_model (
    output logic      spi_clock_out,
    output logic      chip_select_n_out,
    output logic      serial_data_out,
    input  wire logic serial_wire_in
);
    localparam int HALF_NS = 24; // half of 48 ns period
    initial begin
        spi_clock_out     = 1'b0;
        chip_select_n_out = 1'b1;
        serial_data_out   = 1'b0;
    end
    // one frame of n clocks; tx msb goes first, rx gathers bits
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        chip_select_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_out = tx[31-i];
            #HALF_NS spi_clock_out = 1'b1;
            rx = {rx[30:0], serial_wire_in};
            #HALF_NS spi_clock_out = 1'b0;
        end
        #HALF_NS chip_select_n_out = 1'b1;
        serial_data_out = ~serial_data_out; // stale bit inverted once released
        #100;
    endtask : frame
endmodule : cfd_host_model

// >>> bench/cfd_spi_fault_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module cfd_spi_fault_tb_top;
    import cfd_pkg::*;
    logic          clock_in = 1'b0;
    logic          reset_in = 1'b1;
    logic          bus_dominant_in = 1'b0;
    cfd_fault_type fault_detect_in = '0;
    logic          sleep_fault_in = 1'b0;
    logic          fail_safe_enable_in = 1'b0;
    logic          wake_request_in = 1'b0;
    logic          spi_clock_in, chip_select_n_in, serial_in;
    logic          serial_out_out, serial_out_oe_n_out, err_out, sleep_out, fs_out;
    logic [7:0]    flags_out;
    int            fail_count = 0, num_checks = 0, cycles = 0;
    logic [31:0]   seed = 32'hd438, rx;
    logic [6:0]    fset, mask;
    wire           serial_wire = serial_out_oe_n_out ? 1'bz : serial_out_out; // shared line
    always #5 clock_in = ~clock_in;
    cfd_spi_fault uut (.clock_in(clock_in), .reset_in(reset_in), .spi_clock_in(spi_clock_in),
        .chip_select_n_in(chip_select_n_in), .serial_in(serial_in),
        .serial_out_out(serial_out_out), .serial_out_oe_n_out(serial_out_oe_n_out),
        .bus_dominant_in(bus_dominant_in), .fault_detect_in(fault_detect_in),
        .sleep_fault_in(sleep_fault_in), .fail_safe_enable_in(fail_safe_enable_in),
        .wake_request_in(wake_request_in), .bus_fault_status_flags_out(flags_out),
        .serial_frame_error_flag_out(err_out), .sleep_mode_out(sleep_out),
        .fail_safe_mode_out(fs_out));
    cfd_host_model host (.spi_clock_out(spi_clock_in), .chip_select_n_out(chip_select_n_in),
        .serial_data_out(serial_in), .serial_wire_in(serial_wire));
    // repeatable pseudo random source
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // expected global status byte
    function automatic logic [7:0] status_of(input logic [6:0] f, input logic e);
        return {(|f) | e, e, 5'h00, |f};
    endfunction : status_of
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wait_cyc
    // long dominant bits, each followed by a release
    task automatic release_bus(input int n);
        repeat (n) begin
            @(posedge clock_in) bus_dominant_in <= 1'b1;
            wait_cyc(210);
            @(posedge clock_in) bus_dominant_in <= 1'b0;
            wait_cyc(20);
        end
    endtask : release_bus
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // hang guard
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        wait_cyc(12);
        reset_in <= 1'b0;
        wait_cyc(8);
        host.frame(16, {8'hA8, 24'h0}, rx);
        `CHK("status_rst", 8'h00, rx[15:8]);
        `CHK("flags_rst", 8'h00, rx[7:0]);
        $display("test reset finished");
        seed = xorshift(seed);
        fset = seed[6:0] | 7'h01;
        @(posedge clock_in) fault_detect_in <= fset;
        release_bus(3);
        `CHK("flags_3rel", 8'h00, flags_out);
        release_bus(1);
        `CHK("flags_4rel", {1'b0, fset}, flags_out);
        @(posedge clock_in) fault_detect_in <= '0;
        $display("test detect finished");
        host.frame(32, {8'hA6, 24'h0}, rx);
        `CHK("burst_status", status_of(fset, 1'b0), rx[31:24]);
        `CHK("burst_data", {8'h00, 1'b0, fset, 8'h00}, rx[23:0]);
        host.frame(16, {8'hA9, 24'h0}, rx);
        `CHK("write_zero", {1'b0, fset}, flags_out);
        host.frame(15, {8'hA9, 8'hFF, 16'h0}, rx);
        `CHK("short_err", 1'b1, err_out);
        `CHK("short_flags", {1'b0, fset}, flags_out);
        seed = xorshift(seed);
        mask = seed[6:0];
        host.frame(16, {8'hA9, 1'b0, mask, 16'h0}, rx);
        `CHK("write_status", status_of(fset, 1'b1), rx[15:8]);
        `CHK("clear_mask", {1'b0, fset & ~mask}, flags_out);
        host.frame(23, {8'hA9, 8'hFF, 16'h0}, rx);
        `CHK("part_commit", 8'h00, flags_out);
        host.frame(16, {8'hA1, 8'h40, 16'h0}, rx);
        `CHK("err_status", status_of(7'h00, 1'b1), rx[15:8]);
        `CHK("err_clear", 1'b0, err_out);
        $display("test serial finished");
        @(posedge clock_in) sleep_fault_in <= 1'b1;
        wait_cyc(10);
        @(posedge clock_in) fail_safe_enable_in <= 1'b1;
        wait_cyc(10);
        `CHK("sleep_stays", 2'b10, {sleep_out, fs_out});
        @(posedge clock_in) begin
            wake_request_in <= 1'b1;
            sleep_fault_in  <= 1'b0;
        end
        wait_cyc(10);
        @(posedge clock_in) wake_request_in <= 1'b0;
        wait_cyc(5);
        @(posedge clock_in) sleep_fault_in <= 1'b1;
        wait_cyc(10);
        `CHK("fail_safe", 2'b01, {sleep_out, fs_out});
        $display("test mode finished");
        tally_and_finish();
    end
endmodule : cfd_spi_fault_tb_top
bind cfd_spi_fault cfd_spi_fault_properties chk (.clock_in, .reset_in, .spi_clock_in,
    .chip_select_n_in, .serial_out_out, .serial_out_oe_n_out, .fault_detect_in,
    .bus_fault_status_flags_out, .serial_frame_error_flag_out, .sleep_mode_out,
    .fail_safe_mode_out);
